// ---- frmfs_pkg.sv ----
// constants, types and presets for the fifo reset-mode and flag-select block
// Overview of operation
// - In standard mode the shared flag pin shows memory full, and writes are refused while it does.
// - In fall-through mode the same pin shows input ready, meaning room exists for another write.
// - Both default-offset select pins and the offset-access pin are sampled during master reset.
// - Those three sampled levels pick one of eight preset offsets for the almost-empty and almost-full flags.
// - The timing-mode pin is sampled during master reset to choose fall-through or standard timing.
// - After master reset the timing-mode pin is the serial data input that shifts in the offset values.
// - The empty pin shows memory empty in standard mode and output ready in fall-through mode.
// - The offset-access level sampled at master reset also picks serial or parallel offset programming.
package frmfs_pkg;

  // memory geometry
  localparam int          OFS_W = 10;
  localparam int          CNT_W = 11;
  localparam logic [10:0] DEPTH = 11'h400;
  localparam int          SER_BITS = 2 * OFS_W;
  localparam logic [4:0]  SER_LAST = 5'h13;

  // preset offsets indexed by {offset_access_enable, sel_hi, sel_lo}
  localparam logic [9:0] DEF_OFS [0:7] = '{10'h007, 10'h00f, 10'h01f, 10'h03f,
                                          10'h07f, 10'h0ff, 10'h1ff, 10'h3ff};

  // register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_AE_OFS = 8'h0c;
  localparam logic [7:0] REG_AF_OFS = 8'h10;
  localparam logic [7:0] REG_LEVEL  = 8'h14;

  // status and mask bit positions
  localparam int ST_W        = 5;
  localparam int ST_FULL     = 0;
  localparam int ST_EMPTY    = 1;
  localparam int ST_WR_BLOCK = 2;
  localparam int ST_RD_BLOCK = 3;
  localparam int ST_SER_DONE = 4;

  // config readback bit positions
  localparam int CFG_FALL_THROUGH_TIMING   = 0;
  localparam int CFG_SERIAL = 1;
  localparam int CFG_SEL_LO = 2;

  // reset values and bus answers
  localparam logic [4:0] MASK_RST   = 5'h00;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus channel states
  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } frmfs_wr_t;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } frmfs_rd_t;

endpackage

// ---- frmfs_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module frmfs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } frmfs_sync_t;

  frmfs_sync_t s_q;
  frmfs_sync_t s_d;

  // one flop pair per bit; only the second stage is read outside
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      s_d.meta[i]   = pins_in[i];
      s_d.stable[i] = s_q.meta[i];
    end
  end

  // register both stages
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule

// ---- frmfs_top.sv ----
// fifo reset-time configuration, shared flag pins, offset loading and register slave
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module frmfs_top (
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       master_reset_n_in,
  input  wire logic                       default_offset_sel_lo_in,
  input  wire logic                       default_offset_sel_hi_in,
  input  wire logic                       fallthrough_select_serial_input_in,
  input  wire logic                       serial_clk_in,
  input  wire logic                       offset_access_enable_in,
  input  wire logic                       wr_en_in,
  input  wire logic                       rd_en_in,
  input  wire logic [frmfs_pkg::OFS_W-1:0] offset_data_in,
  output logic                            full_flag_input_ready_n_out,
  output logic                            empty_indicator_n_out,
  output logic                            almost_empty_flag_n_out,
  output logic                            almost_full_flag_n_out,
  output logic                            irq_out,
  input  wire logic [7:0]                 s_axi_awaddr_in,
  input  wire logic                       s_axi_awvalid_in,
  output logic                            s_axi_awready_out,
  input  wire logic [31:0]                s_axi_wdata_in,
  input  wire logic [3:0]                 s_axi_wstrb_in,
  input  wire logic                       s_axi_wvalid_in,
  output logic                            s_axi_wready_out,
  output logic [1:0]                      s_axi_bresp_out,
  output logic                            s_axi_bvalid_out,
  input  wire logic                       s_axi_bready_in,
  input  wire logic [7:0]                 s_axi_araddr_in,
  input  wire logic                       s_axi_arvalid_in,
  output logic                            s_axi_arready_out,
  output logic [31:0]                     s_axi_rdata_out,
  output logic [1:0]                      s_axi_rresp_out,
  output logic                            s_axi_rvalid_out,
  input  wire logic                       s_axi_rready_in
);

  typedef struct packed {
    logic [frmfs_pkg::CNT_W-1:0]    count;
    logic                           fall_through_timing;
    logic                           serial_mode;
    logic [2:0]                     sel;
    logic [frmfs_pkg::OFS_W-1:0]    ae_ofs;
    logic [frmfs_pkg::OFS_W-1:0]    af_ofs;
    logic [frmfs_pkg::SER_BITS-1:0] sreg;
    logic [4:0]                     bits;
    logic                           par_af;
    logic                           sck_d;
    logic                           ff_n;
    logic                           ef_n;
    logic                           pae_n;
    logic                           paf_n;
    logic [frmfs_pkg::ST_W-1:0]     status;
    logic [frmfs_pkg::ST_W-1:0]     mask;
    logic                           irq;
    frmfs_pkg::frmfs_wr_t           wst;
    logic                           awready;
    logic                           wready;
    logic                           aw_got;
    logic                           w_got;
    logic [7:0]                     waddr;
    logic [31:0]                    wdata;
    logic [3:0]                     wstrb;
    logic                           bvalid;
    logic [1:0]                     bresp;
    frmfs_pkg::frmfs_rd_t           rst;
    logic                           arready;
    logic                           rvalid;
    logic [31:0]                    rdata;
    logic [1:0]                     rresp;
  } frmfs_state_t;

  frmfs_state_t                s_q;
  frmfs_state_t                s_d;
  logic [4:0]                  pins_s;
  logic                        mrst_s;
  logic [2:0]                  sel_s;
  logic                        si_s;
  logic                        sck_s;
  logic                        wr_ok;
  logic                        rd_ok;
  logic                        sck_rise;
  logic [frmfs_pkg::ST_W-1:0]  ev;
  logic [31:0]                 wmask;
  logic [31:0]                 wmerge;
  logic [31:0]                 rd_word;
  logic [frmfs_pkg::OFS_W-1:0] def_now;

  // pin synchronisers
  frmfs_sync #(.WIDTH(5)) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .pins_in  ({master_reset_n_in, default_offset_sel_hi_in, default_offset_sel_lo_in,
                fallthrough_select_serial_input_in, serial_clk_in}),
    .sync_out (pins_s)
  );

  // decoded pin levels and memory access qualifiers
  assign mrst_s   = pins_s[4];
  assign sel_s    = {offset_access_enable_in, pins_s[3], pins_s[2]};
  assign si_s     = pins_s[1];
  assign sck_s    = pins_s[0];
  assign sck_rise = sck_s && !s_q.sck_d;
  assign wr_ok    = mrst_s && offset_access_enable_in && wr_en_in && s_q.count != frmfs_pkg::DEPTH;
  assign rd_ok    = mrst_s && offset_access_enable_in && rd_en_in && s_q.count != '0;
  assign def_now  = frmfs_pkg::DEF_OFS[s_q.sel];

  // byte-lane merge of the pending write word
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{s_q.wstrb[b]}};
    end
    wmerge = s_q.wdata & wmask;
  end

  // read mux
  always_comb begin
    rd_word = '0;
    if (s_axi_araddr_in == frmfs_pkg::REG_STATUS) begin
      rd_word[frmfs_pkg::ST_W-1:0] = s_q.status;
    end else if (s_axi_araddr_in == frmfs_pkg::REG_MASK) begin
      rd_word[frmfs_pkg::ST_W-1:0] = s_q.mask;
    end else if (s_axi_araddr_in == frmfs_pkg::REG_CONFIG) begin
      rd_word[frmfs_pkg::CFG_FALL_THROUGH_TIMING]               = s_q.fall_through_timing;
      rd_word[frmfs_pkg::CFG_SERIAL]             = s_q.serial_mode;
      rd_word[frmfs_pkg::CFG_SEL_LO +: 3]        = s_q.sel;
    end else if (s_axi_araddr_in == frmfs_pkg::REG_AE_OFS) begin
      rd_word[frmfs_pkg::OFS_W-1:0] = s_q.ae_ofs;
    end else if (s_axi_araddr_in == frmfs_pkg::REG_AF_OFS) begin
      rd_word[frmfs_pkg::OFS_W-1:0] = s_q.af_ofs;
    end else if (s_axi_araddr_in == frmfs_pkg::REG_LEVEL) begin
      rd_word[frmfs_pkg::CNT_W-1:0] = s_q.count;
    end
  end

  // next-state logic: bus slave, fifo level, offset loading, flags
  always_comb begin
    s_d       = s_q;
    ev        = '0;
    s_d.sck_d = sck_s;
    // write channel: address and data in either order, then one response
    case (s_q.wst)
      frmfs_pkg::WR_COLLECT: begin
        if (s_axi_awvalid_in && s_q.awready) begin
          s_d.aw_got  = 1'b1;
          s_d.awready = 1'b0;
          s_d.waddr   = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_q.wready) begin
          s_d.w_got  = 1'b1;
          s_d.wready = 1'b0;
          s_d.wdata  = s_axi_wdata_in;
          s_d.wstrb  = s_axi_wstrb_in;
        end
        if (s_q.aw_got && s_q.w_got) begin
          s_d.aw_got = 1'b0;
          s_d.w_got  = 1'b0;
          s_d.bvalid = 1'b1;
          s_d.bresp  = frmfs_pkg::RESP_OKAY;
          s_d.wst    = frmfs_pkg::WR_RESP;
          if (s_q.waddr == frmfs_pkg::REG_STATUS) begin
            s_d.status = s_q.status & ~wmerge[frmfs_pkg::ST_W-1:0];
          end else if (s_q.waddr == frmfs_pkg::REG_MASK) begin
            s_d.mask = (s_q.mask & ~wmask[frmfs_pkg::ST_W-1:0]) | wmerge[frmfs_pkg::ST_W-1:0];
          end else if (s_q.waddr == frmfs_pkg::REG_AE_OFS) begin
            s_d.ae_ofs = (s_q.ae_ofs & ~wmask[frmfs_pkg::OFS_W-1:0]) | wmerge[frmfs_pkg::OFS_W-1:0];
          end else if (s_q.waddr == frmfs_pkg::REG_AF_OFS) begin
            s_d.af_ofs = (s_q.af_ofs & ~wmask[frmfs_pkg::OFS_W-1:0]) | wmerge[frmfs_pkg::OFS_W-1:0];
          end else if (s_q.waddr != frmfs_pkg::REG_CONFIG && s_q.waddr != frmfs_pkg::REG_LEVEL) begin
            s_d.bresp = frmfs_pkg::RESP_SLVERR;
          end
        end
      end
      frmfs_pkg::WR_RESP: begin
        if (s_axi_bready_in) begin
          s_d.bvalid  = 1'b0;
          s_d.awready = 1'b1;
          s_d.wready  = 1'b1;
          s_d.wst     = frmfs_pkg::WR_COLLECT;
        end
      end
      default: s_d.wst = frmfs_pkg::WR_COLLECT;
    endcase
    // read channel: one cycle to data, held until rready
    case (s_q.rst)
      frmfs_pkg::RD_IDLE: begin
        if (s_axi_arvalid_in) begin
          s_d.rdata   = rd_word;
          s_d.rvalid  = 1'b1;
          s_d.arready = 1'b0;
          s_d.rst     = frmfs_pkg::RD_DATA;
          s_d.rresp   = frmfs_pkg::RESP_OKAY;
          if (s_axi_araddr_in > frmfs_pkg::REG_LEVEL || s_axi_araddr_in[1:0] != 2'h0) begin
            s_d.rresp = frmfs_pkg::RESP_SLVERR;
          end
        end
      end
      frmfs_pkg::RD_DATA: begin
        if (s_axi_rready_in) begin
          s_d.rvalid  = 1'b0;
          s_d.arready = 1'b1;
          s_d.rst     = frmfs_pkg::RD_IDLE;
        end
      end
      default: s_d.rst = frmfs_pkg::RD_IDLE;
    endcase
    // master reset samples the straps; afterwards they are left alone
    if (!mrst_s) begin // straps are taken only while master reset is held
      s_d.fall_through_timing        = si_s;
      s_d.sel         = sel_s;
      s_d.serial_mode = offset_access_enable_in;
      s_d.ae_ofs      = frmfs_pkg::DEF_OFS[sel_s];
      s_d.af_ofs      = frmfs_pkg::DEF_OFS[sel_s];
      s_d.count       = '0;
      s_d.sreg        = '0;
      s_d.bits        = '0;
      s_d.par_af      = 1'b0;
    end else begin
      // memory level; offset access low steers traffic to the offsets
      if (wr_ok && !rd_ok) begin
        s_d.count = s_q.count + 11'h001;
      end else if (rd_ok && !wr_ok) begin
        s_d.count = s_q.count - 11'h001;
      end
      ev[frmfs_pkg::ST_WR_BLOCK] = offset_access_enable_in && wr_en_in && !wr_ok;
      ev[frmfs_pkg::ST_RD_BLOCK] = offset_access_enable_in && rd_en_in && !rd_ok;
      // parallel offset loading: empty offset first, then full offset
      if (!offset_access_enable_in && wr_en_in && !s_q.serial_mode) begin
        if (s_q.par_af) begin
          s_d.af_ofs = offset_data_in;
        end else begin
          s_d.ae_ofs = offset_data_in;
        end
        s_d.par_af = !s_q.par_af;
      end
      // serial loading on the timing-mode pin, msb of the empty offset first
      if (!offset_access_enable_in && s_q.serial_mode && sck_rise) begin
        s_d.sreg = {s_q.sreg[frmfs_pkg::SER_BITS-2:0], si_s};
        s_d.bits = s_q.bits + 5'h01;
        if (s_q.bits == frmfs_pkg::SER_LAST) begin
          s_d.ae_ofs = s_d.sreg[frmfs_pkg::SER_BITS-1:frmfs_pkg::OFS_W];
          s_d.af_ofs = s_d.sreg[frmfs_pkg::OFS_W-1:0];
          s_d.bits   = '0;
          ev[frmfs_pkg::ST_SER_DONE] = 1'b1;
        end
      end
    end
    ev[frmfs_pkg::ST_FULL]  = s_d.count == frmfs_pkg::DEPTH && s_q.count != frmfs_pkg::DEPTH;
    ev[frmfs_pkg::ST_EMPTY] = s_d.count == '0 && s_q.count != '0 && mrst_s;
    // sticky status: a new event beats a clear in the same cycle
    s_d.status = s_d.status | ev;
    s_d.irq    = |(s_d.status & s_d.mask);
    // shared flag pins, active low, meaning chosen by the timing mode
    if (s_d.fall_through_timing) begin
      s_d.ff_n = s_d.count == frmfs_pkg::DEPTH;
      s_d.ef_n = s_d.count == '0;
    end else begin
      s_d.ff_n = s_d.count != frmfs_pkg::DEPTH;
      s_d.ef_n = s_d.count != '0;
    end
    s_d.pae_n = s_d.count > {1'b0, s_d.ae_ofs};
    s_d.paf_n = s_d.count < (frmfs_pkg::DEPTH - {1'b0, s_d.af_ofs});
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q         <= '0;
      s_q.ff_n    <= 1'b1;
      s_q.pae_n   <= 1'b0;
      s_q.paf_n   <= 1'b1;
      s_q.mask    <= frmfs_pkg::MASK_RST;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.ae_ofs  <= frmfs_pkg::DEF_OFS[0];
      s_q.af_ofs  <= frmfs_pkg::DEF_OFS[0];
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign full_flag_input_ready_n_out = s_q.ff_n;
  assign empty_indicator_n_out       = s_q.ef_n;
  assign almost_empty_flag_n_out     = s_q.pae_n;
  assign almost_full_flag_n_out      = s_q.paf_n;
  assign irq_out                     = s_q.irq;
  assign s_axi_awready_out           = s_q.awready;
  assign s_axi_wready_out            = s_q.wready;
  assign s_axi_bvalid_out            = s_q.bvalid;
  assign s_axi_bresp_out             = s_q.bresp;
  assign s_axi_arready_out           = s_q.arready;
  assign s_axi_rvalid_out            = s_q.rvalid;
  assign s_axi_rdata_out             = s_q.rdata;
  assign s_axi_rresp_out             = s_q.rresp;

  // checks on the flag pins, straps and offset loading
  a_full_blocks_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!s_q.fall_through_timing && !s_q.ff_n && wr_en_in && !rd_en_in && mrst_s) |=> s_q.count == $past(s_q.count))
    else $error("write accepted while full");
  a_ready_pin_meaning: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_q.fall_through_timing |-> (s_q.ff_n == (s_q.count == frmfs_pkg::DEPTH)))
    else $error("input ready pin disagrees with level");
  a_std_full_pin: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!s_q.fall_through_timing && s_q.count == frmfs_pkg::DEPTH) |-> !full_flag_input_ready_n_out)
    else $error("full pin not low at full");
  a_sel_sampled: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (nrst_in && !mrst_s) |=> s_q.sel == $past(sel_s))
    else $error("preset select not sampled in master reset");
  a_preset_applied: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(mrst_s) |-> (s_q.ae_ofs == def_now && s_q.af_ofs == def_now))
    else $error("preset offsets not loaded");
  a_mode_sampled: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (nrst_in && !mrst_s)
    |=> (s_q.fall_through_timing == $past(si_s) && s_q.serial_mode == $past(offset_access_enable_in)))
    else $error("timing or load mode not sampled");
  a_serial_shift: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mrst_s && s_q.serial_mode && !offset_access_enable_in && sck_rise && s_q.bits != frmfs_pkg::SER_LAST)
    |=> (s_q.sreg[0] == $past(si_s) && s_q.bits == $past(s_q.bits) + 5'h01))
    else $error("serial bit not shifted");
  a_empty_pin_meaning: assert property (@(posedge clk_in) disable iff (!nrst_in)
    empty_indicator_n_out == (s_q.fall_through_timing ? (s_q.count == '0) : (s_q.count != '0)))
    else $error("empty pin meaning wrong");
  a_parallel_mode: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mrst_s && !s_q.serial_mode && sck_rise) |=> s_q.bits == '0)
    else $error("serial path active in parallel mode");
  a_config_held: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mrst_s && $past(mrst_s)) |-> ($stable(s_q.fall_through_timing) && $stable(s_q.sel) && $stable(s_q.serial_mode)))
    else $error("configuration changed outside master reset");

endmodule

// ---- frmfs_placeholder_unused.sv ----
// intentionally empty
`timescale 1ns/100ps

// ---- frmfs_host.sv ----
// host model driving master reset, straps, offset loading and fifo traffic
`timescale 1ns/100ps
module frmfs_host (
  input  wire logic clk_in,
  output logic      mrst_n_out,
  output logic      sel_lo_out,
  output logic      sel_hi_out,
  output logic      si_out,
  output logic      sclk_out,
  output logic      access_out,
  output logic      wr_out,
  output logic      rd_out,
  output logic [9:0] data_out
);
  // idle levels: master reset released, memory traffic selected
  initial begin
    {mrst_n_out, sel_lo_out, sel_hi_out, si_out, sclk_out, access_out, wr_out, rd_out} = 8'h84;
    data_out = 10'h000;
  end
  // straps held across master reset; read port is synchronous, so both timing modes are legal
  task automatic mreset(input logic ld, input logic hi, input logic lo, input logic fw);
    {access_out, sel_hi_out, sel_lo_out, si_out} <= {ld, hi, lo, fw};
    mrst_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    mrst_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask
  // n back-to-back writes or reads with offset access held high
  task automatic burst(input logic wr, input int n);
    access_out <= 1'b1;
    wr_out <= wr;
    rd_out <= !wr;
    repeat (n) @(posedge clk_in);
    {wr_out, rd_out} <= 2'b00;
    @(posedge clk_in);
  endtask
  // one parallel offset write, offset access low targets the offset registers
  task automatic poke(input logic [9:0] d);
    access_out <= 1'b0;
    data_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    @(posedge clk_in);
  endtask
  // serial frame msb first; the shift clock stands still outside the frame
  task automatic shift(input logic [19:0] v);
    access_out <= 1'b0;
    for (int i = 19; i >= 0; i--) begin
      si_out <= v[i];
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    si_out <= !v[0];
    repeat (6) @(posedge clk_in);
  endtask
endmodule

// ---- frmfs_top_tb.sv ----
// self-checking bench for the reset-mode and flag-select block
`timescale 1ns/100ps
module frmfs_top_tb;
  // strap row {ld, hi, lo, fw}, config readback, preset offset
  typedef struct packed {logic [3:0] s; logic [4:0] cfg; logic [9:0] ofs;} frmfs_row_t;
  localparam frmfs_row_t ROWS [0:7] = '{'{4'h0, 5'h00, 10'h007}, '{4'h3, 5'h05, 10'h00f},
    '{4'h5, 5'h09, 10'h01f}, '{4'h6, 5'h0c, 10'h03f}, '{4'h8, 5'h12, 10'h07f},
    '{4'hb, 5'h17, 10'h0ff}, '{4'hd, 5'h1b, 10'h1ff}, '{4'he, 5'h1e, 10'h3ff}};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        mrst_n, sel_lo, sel_hi, si, sclk, access, wr, rd, ff_n, ef_n, ae_n, af_n, irq;
  logic [9:0]  odata;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] d;
  int          fails = 0, num_checks = 0, cyc = 0;
  frmfs_host host (.clk_in(clk), .mrst_n_out(mrst_n), .sel_lo_out(sel_lo), .sel_hi_out(sel_hi), .si_out(si),
    .sclk_out(sclk), .access_out(access), .wr_out(wr), .rd_out(rd), .data_out(odata));
  frmfs_top dut (.clk_in(clk), .nrst_in(nrst), .master_reset_n_in(mrst_n), .default_offset_sel_lo_in(sel_lo),
    .default_offset_sel_hi_in(sel_hi), .fallthrough_select_serial_input_in(si), .serial_clk_in(sclk),
    .offset_access_enable_in(access), .wr_en_in(wr), .rd_en_in(rd), .offset_data_in(odata),
    .full_flag_input_ready_n_out(ff_n), .empty_indicator_n_out(ef_n), .almost_empty_flag_n_out(ae_n),
    .almost_full_flag_n_out(af_n), .irq_out(irq), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  // clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // axi write: handshakes judged at the settled half of the cycle, released after that edge
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic haw, hw, hb;
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'b111;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clk);
      haw = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (haw) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a);
    logic har, hr;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    hr = 1'b0;
    while (!hr) begin
      @(negedge clk);
      har = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (har) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk({30'h0, r}, {30'h0, frmfs_pkg::RESP_OKAY});
    chk(d, exp);
  endtask
  // pin check {full/ready, empty/ready, almost empty, almost full, irq}
  task automatic pins(input logic [4:0] exp);
    @(negedge clk);
    chk({27'h0, ff_n, ef_n, ae_n, af_n, irq}, {27'h0, exp});
    @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    pins(5'b10010);
    foreach (ROWS[i]) begin
      host.mreset(ROWS[i].s[3], ROWS[i].s[2], ROWS[i].s[1], ROWS[i].s[0]);
      pins({!ROWS[i].s[0], ROWS[i].s[0], 3'b010});
      rchk(frmfs_pkg::REG_CONFIG, {27'h0, ROWS[i].cfg});
      rchk(frmfs_pkg::REG_AE_OFS, {22'h0, ROWS[i].ofs});
      rchk(frmfs_pkg::REG_AF_OFS, {22'h0, ROWS[i].ofs});
    end
    host.shift({10'h2a5, 10'h15a});
    rchk(frmfs_pkg::REG_AE_OFS, 32'h2a5);
    rchk(frmfs_pkg::REG_AF_OFS, 32'h15a);
    rchk(frmfs_pkg::REG_CONFIG, 32'h1e);
    host.mreset(1'b0, 1'b0, 1'b0, 1'b0);
    host.shift({10'h155, 10'h2aa});
    rchk(frmfs_pkg::REG_AE_OFS, 32'h007);
    host.poke(10'h011);
    host.poke(10'h3f0);
    rchk(frmfs_pkg::REG_AE_OFS, 32'h011);
    rchk(frmfs_pkg::REG_AF_OFS, 32'h3f0);
    host.burst(1'b1, 1023);
    pins(5'b11100);
    host.burst(1'b1, 1);
    pins(5'b01100);
    host.burst(1'b1, 1);
    rchk(frmfs_pkg::REG_LEVEL, 32'h400);
    axw(frmfs_pkg::REG_MASK, 32'h04);
    pins(5'b01101);
    axw(frmfs_pkg::REG_STATUS, 32'h04);
    pins(5'b01100);
    rchk(frmfs_pkg::REG_CONFIG, 32'h00);
    host.burst(1'b0, 1024);
    pins(5'b10010);
    axw(8'h40, 32'h1);
    chk({30'h0, r}, {30'h0, frmfs_pkg::RESP_SLVERR});
    axr(8'h40);
    chk({30'h0, r}, {30'h0, frmfs_pkg::RESP_SLVERR});
    host.mreset(1'b1, 1'b0, 1'b0, 1'b1);
    pins(5'b01010);
    host.burst(1'b1, 1);
    pins(5'b00010);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    pins(5'b10010);
    wrap_up();
  end
endmodule
